// [adcsc_pkg.sv]
package adcsc_pkg;

  // ********************************************************
  // Register map (byte offsets)
  // ********************************************************
  localparam logic [7:0] ADCSC_CTL0_OFS = 8'h00;
  localparam logic [7:0] ADCSC_CTL1_OFS = 8'h04;
  localparam logic [7:0] ADCSC_STAT_OFS = 8'h08;
  localparam logic [7:0] ADCSC_MASK_OFS = 8'h0C;

  // ********************************************************
  // Primary control fields
  // ********************************************************
  localparam int ADCSC_SC_BIT     = 0;
  localparam int ADCSC_ENC_BIT    = 1;
  localparam int ADCSC_TOVIE_BIT  = 2;
  localparam int ADCSC_OVIE_BIT   = 3;
  localparam int ADCSC_PWR_BIT    = 4;
  localparam int ADCSC_REFERENCE_POWER_BIT  = 5;
  localparam int ADCSC_REFSEL_BIT = 6;
  localparam int ADCSC_MSC_BIT    = 7;
  localparam int ADCSC_SHTLO_LSB  = 8;
  localparam int ADCSC_SHTHI_LSB  = 12;

  // ********************************************************
  // Secondary control fields
  // ********************************************************
  localparam int ADCSC_BUSY_BIT   = 0;
  localparam int ADCSC_SEQ_LSB    = 1;
  localparam int ADCSC_DIV_LSB    = 5;
  localparam int ADCSC_SAMPLE_INPUT_INVERT_BIT   = 8;
  localparam int ADCSC_SHP_BIT    = 9;
  localparam int ADCSC_SHS_LSB    = 10;
  localparam int ADCSC_STADDR_LSB = 12;

  // Bits that only change while conversion is disabled
  localparam logic [15:0] ADCSC_CTL0_LOCK = 16'hFFC0;
  localparam logic [15:0] ADCSC_CTL1_LOCK = 16'hFFFE;
  localparam logic [15:0] ADCSC_CTL_RST   = 16'h0000;
  localparam logic [2:0]  ADCSC_IRQ_RST   = 3'h0;
  localparam logic [2:0]  ADCSC_DIV_RST   = 3'h0;
  localparam logic [10:0] ADCSC_CNT_RST   = 11'h000;
  localparam logic [10:0] ADCSC_CNT_LAST  = 11'h001;

  // Status bits: conversion done, memory overflow, time overflow
  localparam int ADCSC_IRQ_DONE = 0;
  localparam int ADCSC_IRQ_MOVF = 1;
  localparam int ADCSC_IRQ_TOVF = 2;

  localparam logic [1:0] ADCSC_SRC_SW     = 2'h0;
  localparam logic [1:0] ADCSC_SRC_TA1    = 2'h1;
  localparam logic [1:0] ADCSC_SRC_TB0    = 2'h2;
  localparam logic [1:0] ADCSC_SEQ_SINGLE = 2'h0;
  localparam logic [1:0] ADCSC_SEQ_CHAIN  = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcsc_state_e;

  // Sampling period in converter clock cycles
  function automatic logic [10:0] adcsc_sample_cycles(input logic [3:0] code);
    logic [10:0] n;
    n = 11'h400;
    unique case (code)
      4'h0: n = 11'h004;
      4'h1: n = 11'h008;
      4'h2: n = 11'h010;
      4'h3: n = 11'h020;
      4'h4: n = 11'h040;
      4'h5: n = 11'h060;
      4'h6: n = 11'h080;
      4'h7: n = 11'h0C0;
      4'h8: n = 11'h100;
      4'h9: n = 11'h180;
      4'hA: n = 11'h200;
      4'hB: n = 11'h300;
      default: n = 11'h400;
    endcase
    return n;
  endfunction

endpackage

// [adcsc_sample_timer.sv]
`timescale 1ns/10ps
module adcsc_sample_timer
  import adcsc_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [2:0] div_code_in,
  input  wire logic       start_in,
  input  wire logic [3:0] period_code_in,
  output logic            tick_out,
  output logic            done_out
);

  logic [2:0]  div_cnt_q;
  logic        tick_q;
  logic [10:0] cnt_q;
  logic        run_q;
  logic        done_q;

  // ********************************************************
  // Converter clock divider
  // ********************************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      div_cnt_q <= ADCSC_DIV_RST;
      tick_q    <= 1'b0;
    end else begin
      tick_q    <= (div_cnt_q == div_code_in);
      div_cnt_q <= (div_cnt_q == div_code_in) ? ADCSC_DIV_RST : div_cnt_q + 3'h1;
    end
  end

  // ********************************************************
  // Sampling period counter
  // ********************************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_q  <= ADCSC_CNT_RST;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_in) begin
        cnt_q <= adcsc_sample_cycles(period_code_in);
        run_q <= 1'b1;
      end else if (run_q && tick_q) begin
        cnt_q <= cnt_q - ADCSC_CNT_LAST;
        if (cnt_q == ADCSC_CNT_LAST) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign tick_out = tick_q;
  assign done_out = done_q;

  AST_DIV_GAP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (tick_q && div_code_in != 3'h0 && $stable(div_code_in)) |=> !tick_q)
    else $error("converter clock tick repeated with divider above one");

  AST_MIN_SAMPLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    start_in |=> (run_q && !done_q)[*4])
    else $error("sampling period shorter than four cycles");

endmodule

// [adcsc_ctrl.sv]
`timescale 1ns/10ps
module adcsc_ctrl
  import adcsc_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        timer_a_out1_in,
  input  wire logic        timer_b_out0_in,
  input  wire logic        timer_b_out1_in,
  input  wire logic        global_interrupt_enable_in,
  input  wire logic        conv_done_in,
  input  wire logic        seq_last_in,
  input  wire logic [3:0]  cur_mem_in,
  input  wire logic        mem_overflow_in,
  output logic             sampling_signal_out,
  output logic             conv_start_out,
  output logic      [3:0]  start_memory_address_out,
  output logic      [1:0]  sequence_mode_out,
  output logic             converter_clock_tick_out,
  output logic             reference_power_out,
  output logic             reference_level_select_out,
  output logic             converter_power_out,
  output logic             conversion_enable_out,
  output logic             irq_out
);

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic         ap;
  logic         wr_pend_q;
  logic         rd_pend_q;
  logic [7:0]   addr_q;
  logic [31:0]  hrdata_q;
  logic         hready_q;
  logic [31:0]  rd_val;
  logic [15:0]  ctl0_q;
  logic [15:0]  ctl1_q;
  logic [2:0]   stat_q;
  logic [2:0]   mask_q;
  logic         irq_q;
  logic         ref_lvl_q;
  logic         wr_ctl0;
  logic         wr_ctl1;
  logic [2:0]   sync1_q;
  logic [2:0]   sync2_q;
  logic [2:0]   sync3_q;
  logic [2:0]   clean_q;
  logic         lvl;
  logic         lvl_q;
  logic         edge_hit;
  adcsc_state_e st_q;
  adcsc_state_e st_d;
  logic         use_tmr_q;
  logic         use_tmr_d;
  logic         tmr_go;
  logic         tmr_go_q;
  logic         tmr_done;
  logic         tmr_tick;
  logic         cstart;
  logic         cstart_q;
  logic         samp_q;
  logic         tovf;
  logic         msc_eff;
  logic [3:0]   period_code;
  logic [2:0]   irq_en;

  wire logic conversion_enable   = ctl0_q[ADCSC_ENC_BIT];
  wire logic pwr   = ctl0_q[ADCSC_PWR_BIT];
  wire logic sample_pulse_mode   = ctl1_q[ADCSC_SHP_BIT];
  wire logic [1:0] seq = ctl1_q[ADCSC_SEQ_LSB +: 2];
  wire logic [1:0] shs = ctl1_q[ADCSC_SHS_LSB +: 2];

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************
  assign ap      = hsel_in && htrans_in[1] && hready_in;
  assign wr_ctl0 = wr_pend_q && reg_hit(addr_q, ADCSC_CTL0_OFS);
  assign wr_ctl1 = wr_pend_q && reg_hit(addr_q, ADCSC_CTL1_OFS);

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= ap && hwrite_in;
      rd_pend_q <= ap && !hwrite_in;
      if (ap) begin
        addr_q <= haddr_in[7:0];
      end
    end
  end

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      hready_q <= !(ap && !hwrite_in);
      if (rd_pend_q) begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_hit(addr_q, ADCSC_CTL0_OFS)) begin
      rd_val[15:0] = ctl0_q;
    end else if (reg_hit(addr_q, ADCSC_CTL1_OFS)) begin
      rd_val[15:0] = {ctl1_q[15:1], st_q != ST_IDLE};
    end else if (reg_hit(addr_q, ADCSC_STAT_OFS)) begin
      rd_val[2:0] = stat_q;
    end else if (reg_hit(addr_q, ADCSC_MASK_OFS)) begin
      rd_val[2:0] = mask_q;
    end
  end

  // ********************************************************
  // Control registers
  // ********************************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ctl0_q <= ADCSC_CTL_RST;
    end else if (wr_ctl0) begin
      ctl0_q[15:1] <= conversion_enable ? ((ctl0_q[15:1] & ADCSC_CTL0_LOCK[15:1]) |
                             (hwdata_in[15:1] & ~ADCSC_CTL0_LOCK[15:1]))
                          : hwdata_in[15:1];
      ctl0_q[ADCSC_SC_BIT] <= hwdata_in[ADCSC_SC_BIT];
    end else begin
      ctl0_q[ADCSC_SC_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ctl1_q <= ADCSC_CTL_RST;
    end else if (wr_ctl1 && !conversion_enable) begin
      ctl1_q <= {hwdata_in[15:1], 1'b0};
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  assign irq_en = {ctl0_q[ADCSC_TOVIE_BIT], ctl0_q[ADCSC_OVIE_BIT], 1'b1};

  // A new event wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      stat_q <= ADCSC_IRQ_RST;
      mask_q <= ADCSC_IRQ_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr_pend_q && reg_hit(addr_q, ADCSC_STAT_OFS)) ?
                            hwdata_in[2:0] : 3'h0)) |
                {tovf, mem_overflow_in, conv_done_in};
      if (wr_pend_q && reg_hit(addr_q, ADCSC_MASK_OFS)) begin
        mask_q <= hwdata_in[2:0];
      end
      irq_q <= global_interrupt_enable_in && |(stat_q & mask_q & irq_en);
    end
  end

  // ********************************************************
  // Trigger inputs
  // ********************************************************
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        sync3_q[i] <= 1'b0;
        clean_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= (i == 0) ? timer_a_out1_in : (i == 1) ? timer_b_out0_in : timer_b_out1_in;
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) begin
          clean_q[i] <= sync3_q[i];
        end
      end
    end
  end

  always_comb begin
    unique case (shs)
      ADCSC_SRC_SW:  lvl = ctl0_q[ADCSC_SC_BIT];
      ADCSC_SRC_TA1: lvl = clean_q[0];
      ADCSC_SRC_TB0: lvl = clean_q[1];
      default:       lvl = clean_q[2];
    endcase
    lvl = lvl ^ ctl1_q[ADCSC_SAMPLE_INPUT_INVERT_BIT];
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl;
    end
  end

  assign edge_hit = lvl && !lvl_q;

  // ********************************************************
  // Sample and conversion sequencing
  // ********************************************************
  assign msc_eff     = ctl0_q[ADCSC_MSC_BIT] && (seq != ADCSC_SEQ_SINGLE);
  assign period_code = cur_mem_in[3] ? ctl0_q[ADCSC_SHTHI_LSB +: 4]
                                     : ctl0_q[ADCSC_SHTLO_LSB +: 4];
  // An edge that lands while busy is a conversion-time overflow
  assign tovf        = edge_hit && (st_q != ST_IDLE);

  always_comb begin
    st_d      = st_q;
    use_tmr_d = use_tmr_q;
    tmr_go    = 1'b0;
    cstart    = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (edge_hit && conversion_enable && pwr) begin
          st_d      = ST_SAMPLE;
          use_tmr_d = sample_pulse_mode;
          tmr_go    = sample_pulse_mode;
        end
      end
      ST_SAMPLE: begin
        if (use_tmr_q ? tmr_done : !lvl) begin
          st_d   = ST_CONVERT;
          cstart = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (conv_done_in) begin
          if (!conversion_enable || seq == ADCSC_SEQ_SINGLE ||
              (seq == ADCSC_SEQ_CHAIN && seq_last_in)) begin
            st_d = ST_IDLE;
          end else if (msc_eff) begin
            st_d      = ST_SAMPLE;
            use_tmr_d = 1'b1;
            tmr_go    = 1'b1;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_q      <= ST_IDLE;
      use_tmr_q <= 1'b0;
      tmr_go_q  <= 1'b0;
      cstart_q  <= 1'b0;
      samp_q    <= 1'b0;
      ref_lvl_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      use_tmr_q <= use_tmr_d;
      tmr_go_q  <= tmr_go;
      cstart_q  <= cstart;
      samp_q    <= (st_d == ST_SAMPLE);
      ref_lvl_q <= ctl0_q[ADCSC_REFSEL_BIT] && ctl0_q[ADCSC_REFERENCE_POWER_BIT];
    end
  end

  // Timer start is registered; the period code is sampled on that edge
  adcsc_sample_timer u_timer (
    .mclk_in        (mclk_in),
    .rst_b_in       (rst_b_in),
    .div_code_in    (ctl1_q[ADCSC_DIV_LSB +: 3]),
    .start_in       (tmr_go_q),
    .period_code_in (period_code),
    .tick_out       (tmr_tick),
    .done_out       (tmr_done)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  assign hrdata_out                 = hrdata_q;
  assign hreadyout_out              = hready_q;
  assign hresp_out                  = 1'b0;
  assign sampling_signal_out        = samp_q;
  assign conv_start_out             = cstart_q;
  assign start_memory_address_out   = ctl1_q[ADCSC_STADDR_LSB +: 4];
  assign sequence_mode_out          = seq;
  assign converter_clock_tick_out   = tmr_tick;
  assign reference_power_out        = ctl0_q[ADCSC_REFERENCE_POWER_BIT];
  assign reference_level_select_out = ref_lvl_q;
  assign converter_power_out        = pwr;
  assign conversion_enable_out      = conversion_enable;
  assign irq_out                    = irq_q;

  // ********************************************************
  // Checks
  // ********************************************************
  AST_SC_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (ctl0_q[ADCSC_SC_BIT] && !wr_ctl0) |=> !ctl0_q[ADCSC_SC_BIT])
    else $error("software start bit did not clear itself");

  AST_NO_START_OFF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_IDLE && !conversion_enable) |=> (st_q == ST_IDLE) && !samp_q)
    else $error("sampling began with conversion disabled");

  AST_ONE_WRITE_START: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (wr_ctl0 && hwdata_in[1:0] == 2'h3 && st_q == ST_IDLE && pwr && hwdata_in[4]
     && shs == ADCSC_SRC_SW && !ctl1_q[ADCSC_SAMPLE_INPUT_INVERT_BIT]) |=> ##1 (st_q == ST_SAMPLE))
    else $error("combined enable and start write did not start sampling");

  AST_EDGE_EACH: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_CONVERT && conv_done_in && !msc_eff) |=> st_q == ST_IDLE)
    else $error("next sample started without a trigger edge");

  AST_AUTO_NEXT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_CONVERT && conv_done_in && msc_eff && conversion_enable && !seq_last_in)
    |=> st_q == ST_SAMPLE && tmr_go_q)
    else $error("multi-conversion did not restart sampling");

  AST_SINGLE_MODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_CONVERT && conv_done_in && seq == ADCSC_SEQ_SINGLE) |=> st_q == ST_IDLE)
    else $error("single conversion mode did not stop");

  AST_REF_LEVEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ref_lvl_q |-> $past(ctl0_q[ADCSC_REFERENCE_POWER_BIT]))
    else $error("reference level raised while reference off");

  AST_IRQ_GATE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    irq_q |-> $past(global_interrupt_enable_in) && $past(|(stat_q & mask_q & irq_en)))
    else $error("interrupt raised without global or local enable");

  AST_LOCKED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (wr_ctl1 && conversion_enable) |=> $stable(ctl1_q))
    else $error("locked configuration changed while enabled");

  CVR_CONV_START: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    cstart_q);
  CVR_AUTO: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    st_q == ST_CONVERT && conv_done_in && msc_eff ##1 st_q == ST_SAMPLE);
  CVR_TOVF: cover property (@(posedge mclk_in) disable iff (!rst_b_in) tovf);
  CVR_IRQ: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $rose(irq_q));

endmodule

// [adcsc_core_model.sv]
`timescale 1ns/10ps
module adcsc_core_model
  import adcsc_pkg::*;
#(
  parameter int CONV_CYCLES = 13,
  parameter int SEQ_LEN     = 3
)
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       conv_start_in,
  input  wire logic [3:0] start_addr_in,
  input  wire logic [1:0] seq_mode_in,
  input  wire logic       ovf_req_in,
  output logic            conv_done_out,
  output logic            seq_last_out,
  output logic      [3:0] cur_mem_out,
  output logic            mem_overflow_out
);
  // ****
  // Conversion timing
  // ****
  int cnt_q;
  int idx_q;

  // A start accepted in the same write as the enable is served like any other
  always_ff @(posedge mclk_in) begin
    conv_done_out <= 1'b0;
    if (!rst_b_in) begin
      cnt_q <= 0;
      idx_q <= 0;
    end else begin
      // Step on only after the end flag of this memory stood with the done pulse
      if (conv_done_out) begin
        idx_q <= seq_last_out ? 0 : idx_q + 1;
      end
      if (conv_start_in) begin
        cnt_q <= CONV_CYCLES;
      end else if (cnt_q == 1) begin
        cnt_q         <= 0;
        conv_done_out <= 1'b1;
      end else if (cnt_q > 1) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    mem_overflow_out <= rst_b_in & ovf_req_in;
  end

  // Sequence walks upward from the start memory
  assign seq_last_out = (seq_mode_in == ADCSC_SEQ_SINGLE) || (idx_q == SEQ_LEN - 1);
  assign cur_mem_out  = start_addr_in + idx_q[3:0];
endmodule

// [adc_sample_conversion_control_bench.sv]
`timescale 1ns/10ps
module adc_sample_conversion_control_bench
  import adcsc_pkg::*;
;
  logic        mclk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, global_interrupt_enable = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, seq_mode;
  logic [3:1]  trig = 3'h0;
  logic [3:0]  sa, lo, hi, cur_mem, st_addr;
  logic [2:0]  dv;
  logic        hrdy, hresp, samp, cstart, tick, rpow, rlev, cpow, cen, irq;
  logic        done, last, movf, ovf_req = 1'b0;
  int          err_count = 0, n_checks = 0, n_starts = 0, s0, k, n, len;
  int          tab[16] = '{4, 8, 16, 32, 64, 96, 128, 192, 256, 384, 512, 768,
                           1024, 1024, 1024, 1024};

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (cstart === 1'b1) n_starts++;

  adcsc_ctrl u_adcsc_ctrl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .timer_a_out1_in(trig[1]), .timer_b_out0_in(trig[2]),
    .timer_b_out1_in(trig[3]), .global_interrupt_enable_in(global_interrupt_enable), .conv_done_in(done),
    .seq_last_in(last), .cur_mem_in(cur_mem), .mem_overflow_in(movf),
    .sampling_signal_out(samp), .conv_start_out(cstart),
    .start_memory_address_out(st_addr), .sequence_mode_out(seq_mode),
    .converter_clock_tick_out(tick), .reference_power_out(rpow),
    .reference_level_select_out(rlev), .converter_power_out(cpow),
    .conversion_enable_out(cen), .irq_out(irq));

  adcsc_core_model u_adcsc_core_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .conv_start_in(cstart), .start_addr_in(st_addr), .seq_mode_in(seq_mode),
    .ovf_req_in(ovf_req), .conv_done_out(done), .seq_last_out(last),
    .cur_mem_out(cur_mem), .mem_overflow_out(movf));

  // ****
  // Shared tasks
  // ****
  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single word transfer; the data phase waits for ready just like the address phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge mclk_in);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    t = 0;
    do begin @(posedge mclk_in); t++; end while (hrdy !== 1'b1 && t < 64);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? wd : ~wd;
    do begin @(posedge mclk_in); t++; end while (hrdy !== 1'b1 && t < 64);
    rd = hrdata;
    if (t >= 64) begin err_count++; give_verdict(); end
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic wait_starts(input int target);
    int t;
    t = 0;
    while (n_starts < target && t < 12000) begin @(posedge mclk_in); t++; end
    if (t >= 12000) begin err_count++; give_verdict(); end
  endtask

  // Held long enough to pass the input synchroniser and its filter
  task automatic pulse(input int s);
    @(posedge mclk_in); trig[s] <= 1'b1;
    repeat (8) @(posedge mclk_in);
    trig[s] <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h8CA9));
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    chk("irq_rst", irq, 1'b0);
    chk("hresp", hresp, 1'b0);
    foreach (tab[i]) if (i < 5) rdchk("reg_rst", 8'(i * 4), 32'h0);
    for (int i = 0; i < 16; i++) begin
      sa = 4'($urandom()); dv = 3'($urandom()); lo = 4'(i); hi = 4'($urandom());
      bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
      bus(1'b1, ADCSC_CTL1_OFS, {16'h0, sa, 4'h2, dv, 5'h0});
      bus(1'b1, ADCSC_CTL0_OFS, {16'h0, hi, lo, 8'h10});
      s0 = n_starts;
      bus(1'b1, ADCSC_CTL0_OFS, {16'h0, hi, lo, 8'h13});
      k = 0;
      while (samp !== 1'b1 && k < 100) begin @(posedge mclk_in); k++; end
      len = 0;
      while (samp === 1'b1 && len < 9000) begin @(posedge mclk_in); len++; end
      n = tab[sa[3] ? hi : lo] * (int'(dv) + 1);
      chk("sample_len", (len > n - int'(dv) - 1) && (len <= n + 2), 1'b1);
      repeat (3) @(posedge mclk_in);
      chk("sw_start", n_starts, s0 + 1);
      chk("start_addr", st_addr, sa);
      rdchk("ctl0_sc_clear", ADCSC_CTL0_OFS, {16'h0, hi, lo, 8'h12});
      repeat (20) @(posedge mclk_in);
    end
    bus(1'b1, ADCSC_MASK_OFS, 32'h4);
    global_interrupt_enable <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
      bus(1'b1, ADCSC_CTL1_OFS, 32'h200 | (s << 10));
      bus(1'b1, ADCSC_CTL0_OFS, 32'h0496);
      s0 = n_starts;
      pulse(s);
      pulse(s);
      wait_starts(s0 + 1);
      repeat (60) @(posedge mclk_in);
      chk("src_starts", n_starts, s0 + 1);
      chk("tovf_irq", irq, 1'b1);
      rdchk("tovf_flag", ADCSC_STAT_OFS, 32'h5);
      bus(1'b1, ADCSC_STAT_OFS, 32'h7);
    end
    bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
    bus(1'b1, ADCSC_CTL1_OFS, 32'h0602);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h0092);
    s0 = n_starts;
    pulse(1);
    wait_starts(s0 + 3);
    repeat (100) @(posedge mclk_in);
    chk("multi_starts", n_starts, s0 + 3);
    chk("seq_mode", seq_mode, 2'h1);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h12);
    s0 = n_starts;
    for (int e = 1; e < 3; e++) begin
      pulse(1);
      wait_starts(s0 + e);
      repeat (100) @(posedge mclk_in);
      chk("edge_starts", n_starts, s0 + e);
    end
    bus(1'b1, ADCSC_CTL0_OFS, 32'hFFD2);
    rdchk("ctl0_locked", ADCSC_CTL0_OFS, 32'h0012);
    bus(1'b1, ADCSC_CTL1_OFS, 32'h1234);
    rdchk("ctl1_locked", ADCSC_CTL1_OFS, 32'h0602);
    chk("no_start", n_starts, s0 + 2);
    chk("enable_out", cen, 1'b1);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
    bus(1'b1, ADCSC_CTL1_OFS, 32'h0560);
    k = 0;
    repeat (40) begin @(posedge mclk_in); k += int'(tick); end
    chk("tick_rate", k, 10);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h12);
    s0 = n_starts;
    @(posedge mclk_in); trig[1] <= 1'b1;
    repeat (8) @(posedge mclk_in);
    trig[1] <= 1'b0;
    repeat (12) @(posedge mclk_in);
    chk("direct_samp", samp, 1'b1);
    chk("direct_wait", n_starts, s0);
    trig[1] <= 1'b1;
    repeat (12) @(posedge mclk_in);
    chk("direct_end", samp, 1'b0);
    chk("direct_starts", n_starts, s0 + 1);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h50);
    repeat (3) @(posedge mclk_in);
    chk("ref_level_off", {rlev, rpow, cpow, cen}, 4'h2);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h70);
    repeat (3) @(posedge mclk_in);
    chk("ref_level_on", {rlev, rpow}, 2'h3);
    rdchk("unmapped", 8'h10, 32'h0);
    bus(1'b1, ADCSC_STAT_OFS, 32'h7);
    bus(1'b1, ADCSC_MASK_OFS, 32'h2);
    bus(1'b1, ADCSC_CTL0_OFS, 32'h18);
    @(posedge mclk_in); ovf_req <= 1'b1;
    @(posedge mclk_in); ovf_req <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk("movf_irq", irq, 1'b1);
    rdchk("movf_flag", ADCSC_STAT_OFS, 32'h2);
    global_interrupt_enable <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("gie_gate", irq, 1'b0);
    global_interrupt_enable <= 1'b1;
    bus(1'b1, ADCSC_CTL0_OFS, 32'h10);
    repeat (3) @(posedge mclk_in);
    chk("ovie_gate", irq, 1'b0);
    bus(1'b1, ADCSC_STAT_OFS, 32'h2);
    rdchk("flag_clear", ADCSC_STAT_OFS, 32'h0);
    give_verdict();
  end
endmodule
